// ### verilog/sar_device.sv
// Converter end: conversion sequencing, busy, sleep and result bus.
`timescale 1ns/100ps
module sar_device (
  input  wire logic clk,
  input  wire logic rst,
  sar_link_if.device link,
  input  wire logic [11:0] analog_code,
  output logic      asleep,
  output logic      acquiring
);
  // ***************************************************************
  // Types and state
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_ACQ  = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11,
    ST_WAKE = 2'b10
  } dev_state_t;

  localparam int CW = $clog2(sar_pkg::WAKE_CYCLES + 1);

  dev_state_t        state_r;
  dev_state_t        state_nxt;
  logic              start_lvl;
  logic              start_prev_r;
  logic              sleep_r;
  logic [3:0]        step_r;
  logic [CW-1:0]     wake_r;
  logic [11:0]       sample_r;
  logic [11:0]       sar_r;
  logic [11:0]       data_r;
  logic              pend_r;
  logic              cs_lvl;
  logic              rd_lvl;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  pin_sync #(.RST_VAL(1'b1)) u_start (
    .clk   (clk),
    .rst   (rst),
    .pin   (link.conversion_start_n),
    .level (start_lvl)
  );
  pin_sync #(.RST_VAL(1'b1)) u_cs (
    .clk   (clk),
    .rst   (rst),
    .pin   (link.select_n),
    .level (cs_lvl)
  );
  pin_sync #(.RST_VAL(1'b1)) u_rd (
    .clk   (clk),
    .rst   (rst),
    .pin   (link.read_n),
    .level (rd_lvl)
  );

  // ***************************************************************
  // Decoding
  // ***************************************************************
  wire start_fall = start_prev_r & ~start_lvl;
  wire start_rise = ~start_prev_r & start_lvl;
  wire conv_tick  = link.conv_clk_en;
  wire last_step  = (step_r == 4'(sar_pkg::CONV_CYCLES - 1));
  wire [3:0] bit_ix = 4'(sar_pkg::RESULT_W - 1) - (step_r - 4'h1);
  wire bit_step   = (step_r >= 4'h1) && (step_r <= 4'hC);
  wire wake_done  = (wake_r == CW'(sar_pkg::WAKE_CYCLES));
  wire read_en    = ~cs_lvl & ~rd_lvl;
  wire conv_end   = (state_nxt == ST_DONE);
  // A start taken before the last wake-up cycle is loaded when wake-up ends.
  wire conv_load  = (state_nxt == ST_CONV) &&
                    ((state_r != ST_CONV) || start_fall);

  // Trial comparison of the successive-approximation weights.
  function automatic logic [11:0] sar_trial(input logic [11:0] acc,
                                            input logic [3:0]  ix,
                                            input logic [11:0] smp);
    logic [11:0] t;
    t = acc | (12'h001 << ix);
    sar_trial = (t <= smp) ? t : acc;
  endfunction

  // One word feeds the held register and the bus, so the bus leads
  // the busy fall by a clock.
  wire [11:0] data_nxt = conv_end ? sar_trial(sar_r, 4'h0, sample_r)
                                  : data_r;

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACQ: begin
        if (start_fall) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_tick && last_step) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_ACQ;
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_nxt = pend_r ? ST_CONV : ST_ACQ;
        end
      end
    endcase
    if (state_r == ST_CONV && start_fall) begin
      state_nxt = ST_CONV;
    end
    if (sleep_r && start_rise) begin
      state_nxt = ST_WAKE;
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  // A fresh start edge during conversion restarts it from step zero.
  // Sample and step are loaded wherever a conversion begins.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= ST_ACQ;
      start_prev_r <= 1'b1;
      sleep_r      <= 1'b0;
      step_r       <= 4'h0;
      wake_r       <= '0;
      pend_r       <= 1'b0;
      sample_r     <= 12'h000;
      sar_r        <= 12'h000;
    end else begin
      start_prev_r <= start_lvl;
      state_r      <= state_nxt;
      if (conv_load) begin
        sample_r <= analog_code;
        step_r   <= 4'h0;
        sar_r    <= 12'h000;
      end else if (state_r == ST_CONV && conv_tick) begin
        step_r <= step_r + 4'h1;
        if (bit_step) begin
          sar_r <= sar_trial(sar_r, bit_ix, sample_r);
        end
      end
      if (state_r == ST_DONE && !start_lvl) begin
        sleep_r <= 1'b1;
      end else if (sleep_r && start_rise) begin
        sleep_r <= 1'b0;
      end
      if (state_r == ST_WAKE) begin
        wake_r <= wake_r + CW'(1);
        if (start_fall) begin
          pend_r <= 1'b1;
        end
      end else begin
        wake_r <= '0;
        pend_r <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Result register and outputs
  // ***************************************************************
  // Data register loads one cycle before busy falls, so a bus held
  // open shows the new word ahead of the busy edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_r               <= sar_pkg::RESULT_RST;
      link.busy            <= 1'b0;
      link.result_bus_out  <= sar_pkg::RESULT_RST;
      link.result_bus_oe_n <= 1'b1;
      asleep               <= 1'b0;
      acquiring            <= 1'b1;
    end else begin
      data_r    <= data_nxt;
      link.busy <= (state_nxt == ST_CONV) || conv_end;
      link.result_bus_out  <= data_nxt;
      link.result_bus_oe_n <= ~read_en;
      asleep    <= sleep_r;
      acquiring <= (state_nxt == ST_ACQ) && !sleep_r;
    end
  end
endmodule

// ### verilog/sar_pkg.sv
// Shared constants for the converter control and result readout ends.
package sar_pkg;
  // ***************************************************************
  // Widths and timing
  // ***************************************************************
  localparam int RESULT_W       = 12;
  localparam int LSB_DIVISOR    = 4096;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CONV_CYCLES    = 14;
  localparam int ACQ_TIME_NS    = 250;
  localparam int ACQ_CYCLES     =
    (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TIME_NS   = 1000;
  localparam int WAKE_CYCLES    =
    (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CCLK_MAX_KHZ   = 10000;
  localparam int CLK_KHZ        = 20000;
  localparam int CCLK_DIV       =
    (CLK_KHZ + CCLK_MAX_KHZ - 1) / CCLK_MAX_KHZ;
  localparam int DATA_EARLY     = 1;
  localparam logic [11:0] RESULT_RST = 12'h000;
endpackage

// ### verilog/sar_link_if.sv
// Link between converter and host: start, busy, strobes, result bus.
`timescale 1ns/100ps
interface sar_link_if;
  logic                 conversion_start_n;
  logic                 conv_clk_en;
  logic                 busy;
  logic                 select_n;
  logic                 read_n;
  logic [11:0]          result_bus_out;
  logic                 result_bus_oe_n;

  modport device (
    input  conversion_start_n,
    input  conv_clk_en,
    input  select_n,
    input  read_n,
    output busy,
    output result_bus_out,
    output result_bus_oe_n
  );

  modport host (
    output conversion_start_n,
    output conv_clk_en,
    output select_n,
    output read_n,
    input  busy,
    input  result_bus_out,
    input  result_bus_oe_n
  );
endinterface

// ### verilog/pin_sync.sv
// Three-stage synchroniser with agreement of the last two stages.
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change counts only once the second and third stage agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule

// ### verilog/sar_host.sv
// Host end: starts conversions, supplies conversion clock, reads result.
`timescale 1ns/100ps
module sar_host (
  input  wire logic clk,
  input  wire logic rst,
  sar_link_if.host  link,
  input  wire logic start_req,
  input  wire logic sleep_after,
  output logic      ready,
  output logic [11:0] result,
  output logic      result_valid
);
  // ***************************************************************
  // Types and state
  // ***************************************************************
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_START = 3'b001,
    H_BUSY  = 3'b011,
    H_READ  = 3'b010,
    H_ACQ   = 3'b110
  } host_state_t;

  host_state_t state_r;
  logic [3:0]  cnt_r;
  logic [1:0]  div_r;
  logic        busy_s1_r;
  logic        busy_s2_r;
  logic        busy_s3_r;
  logic        busy_lvl_r;
  logic        dummy_r;

  wire busy_seen = busy_lvl_r;
  wire div_tick  = (div_r == 2'(sar_pkg::CCLK_DIV - 1));

  // ***************************************************************
  // Conversion clock divider and busy synchroniser
  // ***************************************************************
  // Divide the system clock so the conversion clock stays at or
  // under its ceiling.
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r               <= 2'h0;
      link.conv_clk_en    <= 1'b0;
      busy_s1_r           <= 1'b0;
      busy_s2_r           <= 1'b0;
      busy_s3_r           <= 1'b0;
      busy_lvl_r          <= 1'b0;
    end else begin
      div_r            <= div_tick ? 2'h0 : div_r + 2'h1;
      link.conv_clk_en <= div_tick;
      busy_s1_r        <= link.busy;
      busy_s2_r        <= busy_s1_r;
      busy_s3_r        <= busy_s2_r;
      if (busy_s2_r == busy_s3_r) begin
        busy_lvl_r <= busy_s3_r;
      end
    end
  end

  // ***************************************************************
  // Host sequencer
  // ***************************************************************
  // Start is driven high from reset so the converter never sees a
  // floating input; the first result is thrown away.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r                 <= H_IDLE;
      cnt_r                   <= 4'h0;
      dummy_r                 <= 1'b1;
      link.conversion_start_n <= 1'b1;
      link.select_n           <= 1'b1;
      link.read_n             <= 1'b1;
      ready                   <= 1'b0;
      result                  <= sar_pkg::RESULT_RST;
      result_valid            <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          ready <= ~dummy_r;
          if (dummy_r || start_req) begin
            link.conversion_start_n <= 1'b0;
            ready   <= 1'b0;
            cnt_r   <= 4'h0;
            state_r <= H_START;
          end
        end
        H_START: begin
          // Start stays low until busy is seen: a one-clock pulse would
          // be filtered out by the converter's input synchroniser.
          if (busy_seen) begin
            link.conversion_start_n <= ~sleep_after;
            state_r <= H_BUSY;
          end
        end
        H_BUSY: begin
          if (!busy_seen) begin
            link.select_n <= 1'b0;
            link.read_n   <= 1'b0;
            cnt_r         <= 4'h0;
            state_r       <= H_READ;
          end
        end
        H_READ: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h5) begin
            link.select_n <= 1'b1;
            link.read_n   <= 1'b1;
            link.conversion_start_n <= 1'b1;
            result       <= link.result_bus_out;
            result_valid <= ~dummy_r;
            dummy_r      <= 1'b0;
            cnt_r        <= 4'h0;
            state_r      <= H_ACQ;
          end
        end
        H_ACQ: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(sar_pkg::WAKE_CYCLES > sar_pkg::ACQ_CYCLES
                         ? 15 : sar_pkg::ACQ_CYCLES)) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verification/sar_link_asserts.sv
// Concurrent checks on the link between the converter and host ends.
`timescale 1ns/100ps
module sar_link_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        conversion_start_n,
  input wire logic        conv_clk_en,
  input wire logic        busy,
  input wire logic        select_n,
  input wire logic        read_n,
  input wire logic [11:0] result_bus_out,
  input wire logic        result_bus_oe_n
);
  // ****************************************************
  // Busy length counter and link properties
  // ****************************************************
  localparam int HI_MIN = 27;
  localparam int HI_MAX = 31;
  logic [7:0] hi_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Counts clocks of busy high; a restart mid-run would not reset it.
  always_ff @(posedge clk) begin
    if (rst || !busy)
      hi_cnt_r <= 8'h00;
    else
      hi_cnt_r <= hi_cnt_r + 8'h01;
  end

  start_busy_a: assert property (
    $fell(conversion_start_n) && !busy |-> ##[1:40] busy)
    else $error("busy did not follow the start edge");
  conv_len_a: assert property (
    $fell(busy) |-> hi_cnt_r >= HI_MIN && hi_cnt_r <= HI_MAX)
    else $error("conversion length off");
  data_end_a: assert property (
    $changed(result_bus_out) |-> busy ##1 !busy)
    else $error("result word changed outside conversion end");
  bus_float_a: assert property (
    $rose(select_n) || $rose(read_n) |-> ##[1:6] result_bus_oe_n)
    else $error("bus not released after strobe rise");
  bus_gate_a: assert property (
    (select_n || read_n) [*6] |-> result_bus_oe_n)
    else $error("bus driven without both strobes");
  bus_drive_a: assert property (
    (!select_n && !read_n) [*6] |-> !result_bus_oe_n)
    else $error("bus not driven with both strobes low");
  read_idle_a: assert property (
    !select_n || !read_n |-> !busy)
    else $error("read during conversion");
  strobe_pair_a: assert property (
    $fell(read_n) |-> $fell(select_n))
    else $error("strobes not asserted together");
  acq_gap_a: assert property (
    $fell(busy) && conversion_start_n |-> conversion_start_n [*5])
    else $error("acquisition window too short");
  clk_rate_a: assert property (
    conv_clk_en |=> !conv_clk_en)
    else $error("conversion clock too fast");

  cover property ($fell(busy));
  cover property (!result_bus_oe_n);
  cover property (!conversion_start_n && $fell(busy));
endmodule

// ### verification/test_sar_adc_conversion_readout.sv
// Self-checking bench joining the converter and host ends.
`timescale 1ns/100ps
module test_sar_adc_conversion_readout;
  typedef struct packed {
    logic [11:0] code;
    logic        slp;
    logic [11:0] exp;
  } row_t;
  localparam int LIM = 400;
  localparam int NR  = 6;
  logic        clk;
  logic        rst;
  logic [11:0] code;
  logic [11:0] code2;
  logic        start_req;
  logic        sleep_after;
  logic        ready;
  logic [11:0] result;
  logic        result_valid;
  logic        asleep;
  logic        acquiring;
  logic [11:0] pb;
  int          failures;
  int          n_checks;
  int          rv_cnt;
  int          n;
  row_t        rows [NR];

  // ****************************************************
  // Ends under test; the second link has its strobes tied low
  // ****************************************************
  sar_link_if lk ();
  sar_link_if lk2 ();
  sar_device i_sar_device (.clk(clk), .rst(rst), .link(lk.device),
    .analog_code(code), .asleep(asleep), .acquiring(acquiring));
  sar_host i_sar_host (.clk(clk), .rst(rst), .link(lk.host),
    .start_req(start_req), .sleep_after(sleep_after), .ready(ready),
    .result(result), .result_valid(result_valid));
  sar_device i_sar_device_b (.clk(clk), .rst(rst), .link(lk2.device),
    .analog_code(code2), .asleep(), .acquiring());
  sar_link_asserts i_sar_link_asserts (.clk(clk), .rst(rst),
    .conversion_start_n(lk.conversion_start_n),
    .conv_clk_en(lk.conv_clk_en), .busy(lk.busy),
    .select_n(lk.select_n), .read_n(lk.read_n),
    .result_bus_out(lk.result_bus_out),
    .result_bus_oe_n(lk.result_bus_oe_n));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Pulse every second clock keeps the conversion clock at 10 MHz.
  always @(negedge clk)
    lk2.conv_clk_en <= rst ? 1'b0 : ~lk2.conv_clk_en;

  // Counts reported results so a reported dummy conversion shows up.
  always @(posedge clk) begin
    if (rst)
      rv_cnt <= 0;
    else if (result_valid === 1'b1)
      rv_cnt <= rv_cnt + 1;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic lim(input int k);
    if (k >= LIM) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
    end
  endtask

  // Reset, then wait for the host to finish its silent first conversion.
  task automatic do_reset;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    chk(lk.busy, 1'b0, "busy in reset");
    chk(lk.result_bus_oe_n, 1'b1, "bus driven in reset");
    chk(lk.conversion_start_n, 1'b1, "start low in reset");
    chk(ready, 1'b0, "ready in reset");
    rst = 1'b0;
    for (n = 0; n < LIM && ready !== 1'b1; n++) @(negedge clk);
    lim(n);
    chk(rv_cnt[11:0], 12'h000, "first result reported");
  endtask

  initial begin
    rst = 1'b1;
    code = 12'h3C3;
    code2 = 12'h5A3;
    start_req = 1'b0;
    sleep_after = 1'b0;
    lk2.conversion_start_n = 1'b1;
    lk2.select_n = 1'b0;
    lk2.read_n = 1'b0;
    rows = '{'{12'h000, 1'b0, 12'h000}, '{12'hFFF, 1'b0, 12'hFFF},
             '{12'h800, 1'b1, 12'h800}, '{12'h7FF, 1'b0, 12'h7FF},
             '{12'hA5C, 1'b1, 12'hA5C}, '{12'h001, 1'b0, 12'h001}};
    do_reset();
    foreach (rows[i]) begin
      code = rows[i].code;
      sleep_after = rows[i].slp;
      start_req = 1'b1;
      if (i > 0 && rows[i-1].slp) begin
        for (n = 0; n < LIM && lk.conversion_start_n !== 1'b1; n++)
          @(negedge clk);
        lim(n);
        for (n = 0; n < LIM && lk.busy !== 1'b1; n++) @(negedge clk);
        lim(n);
        chk(n >= sar_pkg::WAKE_CYCLES, 1'b1, "woke too early");
      end
      // The request is dropped once the host has lowered start.
      for (n = 0; n < LIM && lk.conversion_start_n !== 1'b0; n++)
        @(negedge clk);
      lim(n);
      start_req = 1'b0;
      chk(ready, 1'b0, "ready during conversion");
      for (n = 0; n < LIM && result_valid !== 1'b1; n++) @(negedge clk);
      lim(n);
      chk(result, rows[i].exp, "result word");
      chk(asleep, rows[i].slp, "sleep state");
      if (!rows[i].slp)
        chk(acquiring, 1'b1, "not acquiring");
    end
    // The held word must survive a changing input with no conversion.
    code = 12'hC3C;
    repeat (40) @(negedge clk);
    chk(lk.result_bus_out, rows[NR-1].exp, "idle word changed");
    do_reset();
    // Tied-low strobes: the new word must lead the busy fall.
    lk2.conversion_start_n = 1'b0;
    for (n = 0; n < LIM && lk2.busy !== 1'b1; n++) @(negedge clk);
    lim(n);
    lk2.conversion_start_n = 1'b1;
    for (n = 0; n < LIM && lk2.busy === 1'b1; n++) begin
      pb = lk2.result_bus_out;
      @(negedge clk);
    end
    lim(n);
    chk(pb, code2, "word late at busy fall");
    chk(lk2.result_bus_oe_n, 1'b0, "tied strobes idle");
    lk2.read_n = 1'b1;
    repeat (6) @(negedge clk);
    chk(lk2.result_bus_oe_n, 1'b1, "bus not released");
    lk2.read_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(lk2.result_bus_oe_n, 1'b0, "bus not driven");
    chk(lk2.result_bus_out, code2, "word on bus");
    wrap_up();
  end
endmodule
